// ===== inc/gate_seq_params.svh
// Function
// - pwm rise starts guard in active freewheel, low side sunk
// - after guard, precharge with adaptive current
// - then charge current, measure turn-on delay
// - charge ends at switch node high
// - postcharge ramps one step per cycle
// - adapt only when control field 10/11
// - adaptive code clamped between minimum and max
// - enable write loads min(initial, max)
// - unfiltered: longer raises, shorter lowers
// - step bit picks one or two steps
// - filtered: two agreeing results needed
// - filtered disagreement leaves code unchanged
// - measured delay readable in status register
// - precharge duration programmable; predischarge time only stored and read back
// - pwm fall delayed by guard time in active freewheel
// - hardest sink equals discharge code 63
// - hold current outside switching phases
// - passive freewheel keeps low side off
// - postcharge disable keeps charge current
`ifndef GATE_SEQ_PARAMS_SVH
`define GATE_SEQ_PARAMS_SVH
`define OFS_GEN        8'h00
`define OFS_MODE       8'h04
`define OFS_TIME       8'h08
`define OFS_CUR        8'h0C
`define OFS_MAX        8'h10
`define OFS_INIT       8'h14
`define OFS_TON        8'h18
`define OFS_STAT       8'h1C
`define GEN_AGC_LSB    0
`define GEN_FILT_BIT   2
`define GEN_STEP_BIT   3
`define GEN_PCDIS_BIT  4
`define GEN_HOLD_BIT   5
`define MODE_EN_BIT    0
`define MODE_AFW_BIT   1
`define B1_LSB         8
`define B2_LSB         16
`define RST_PCHG       8'h08
`define RST_PDCHG      8'h08
`define RST_CHG        6'h10
`define RST_DCHG       6'h10
`define RST_FW         6'h10
`define RST_MAX        6'h3F
`define RST_INIT       6'h08
`define RST_TON        8'h20
`define RST_GUARD      8'h10
`define RST_TFLT       8'h20
`define MIN_STEP       6'h01
`define HARD_SINK      6'h3F
`define HOLD_LO        6'h02
`define HOLD_HI        6'h04
`endif

// ===== inc/gate_seq_pkg.sv
package gate_seq_pkg;
    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_GUARD = 7'h02,
        S_PRE   = 7'h04,
        S_CHG   = 7'h08,
        S_POST  = 7'h10,
        S_OFFD  = 7'h20,
        S_DIS   = 7'h40
    } state_t;

    typedef struct packed {
        logic [5:0] cur;
        logic       src;
    } gate_drv_t;

    typedef struct packed {
        state_t      state;
        logic        sync1, sync2, pwm_q;
        logic [7:0]  tmr, meas, meas_stat;
        logic [5:0]  pre_code, app_code;
        logic [1:0]  hist;
        logic [1:0]  adaptive_gate_control_sel;
        logic        filt, step, pcdis, hold_sel, en, afw;
        logic [7:0]  pchg_t, pdchg_t, ton, guard, tflt;
        logic [5:0]  chg, dchg, fw, maxc, init;
        logic        ack;
        logic [31:0] rdat;
        gate_drv_t   hs, ls;
    } st_t;
endpackage : gate_seq_pkg

// ===== hw/gate_turn_on_seq.sv
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "gate_seq_params.svh"
module gate_turn_on_seq
    import gate_seq_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST_B,
    input  wire logic        PWM_IN,
    input  wire logic        SW_HIGH,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic      [5:0]  HS_CUR,
    output logic             HS_SRC,
    output logic      [5:0]  LS_CUR,
    output logic             LS_SRC
);
    localparam st_t RST_VAL = '{state: S_IDLE, pchg_t: `RST_PCHG, pdchg_t: `RST_PDCHG,
        chg: `RST_CHG, dchg: `RST_DCHG, fw: `RST_FW, maxc: `RST_MAX, init: `RST_INIT,
        pre_code: `RST_INIT, ton: `RST_TON, guard: `RST_GUARD, tflt: `RST_TFLT,
        default: '0};

    st_t        q;
    st_t        d;
    state_t     nxt;
    logic       rise;
    logic       fall;
    logic       lng;
    logic       sht;
    logic       up;
    logic       dn;
    logic [5:0] hold;
    logic [31:0] cur_rd;
    logic [31:0] wmrg;

    // smaller of two codes
    function automatic logic [5:0] min6(input logic [5:0] a, input logic [5:0] b);
        return (a < b) ? a : b;
    endfunction : min6

    // phase timer reached its length (zero length ends at once)
    function automatic logic expired(input logic [7:0] t, input logic [7:0] len);
        return ({1'b0, t} + 9'h001) >= {1'b0, len};
    endfunction : expired

    // step code up or down, then clamp into minimum..max
    function automatic logic [5:0] adjust(input logic [5:0] c, input logic u,
                                          input logic n, input logic two,
                                          input logic [5:0] mx);
        logic [6:0] v;
        logic [6:0] s;
        v = {1'b0, c};
        s = two ? 7'h02 : 7'h01;
        if (u) begin
            v = v + s;
        end else if (n) begin
            v = (v > s) ? v - s : 7'h00;
        end
        if (v > {1'b0, mx}) v = {1'b0, mx};
        if (v < {1'b0, `MIN_STEP}) v = {1'b0, `MIN_STEP};
        return v[5:0];
    endfunction : adjust

    // register read image, also base of byte-lane merging on writes
    function automatic logic [31:0] rdval(input st_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            `OFS_GEN: begin
                r[`GEN_AGC_LSB +: 2] = s.adaptive_gate_control_sel;
                r[`GEN_FILT_BIT]     = s.filt;
                r[`GEN_STEP_BIT]     = s.step;
                r[`GEN_PCDIS_BIT]    = s.pcdis;
                r[`GEN_HOLD_BIT]     = s.hold_sel;
            end
            `OFS_MODE: begin
                r[`MODE_EN_BIT]  = s.en;
                r[`MODE_AFW_BIT] = s.afw;
            end
            `OFS_TIME: r = {16'h0000, s.pdchg_t, s.pchg_t};
            `OFS_CUR:  r = {10'h000, s.fw, 2'h0, s.dchg, 2'h0, s.chg};
            `OFS_MAX:  r = {26'h0000000, s.maxc};
            `OFS_INIT: r = {26'h0000000, s.init};
            `OFS_TON:  r = {8'h00, s.tflt, s.guard, s.ton};
            `OFS_STAT: r = {9'h000, s.state, 2'h0, s.app_code, s.meas_stat};
            default:   r = 32'h0000_0000;
        endcase
        return r;
    endfunction : rdval

    // next-state logic for sequencer, adaptation and bus slave
    always_comb begin
        d      = q;
        d.sync1 = PWM_IN;
        d.sync2 = q.sync1;
        d.pwm_q = q.sync2;
        rise   = q.sync2 & ~q.pwm_q;
        fall   = ~q.sync2 & q.pwm_q;
        d.tmr  = q.tmr + 8'h01;
        if (q.meas != 8'hFF) d.meas = q.meas + 8'h01;
        hold   = q.hold_sel ? `HOLD_HI : `HOLD_LO;
        lng    = q.meas > q.ton;
        sht    = q.meas < q.ton;
        up     = 1'b0;
        dn     = 1'b0;
        nxt    = q.state;

        // phase sequencing, timers counted in clock cycles
        unique case (q.state)
            S_IDLE:  nxt = S_IDLE;
            S_GUARD: if (expired(q.tmr, q.guard)) nxt = S_PRE;
            S_PRE:   if (expired(q.tmr, q.pchg_t)) nxt = S_CHG;
            S_CHG:   if (SW_HIGH) nxt = S_POST;
            S_POST:  if (expired(q.tmr, q.tflt)) nxt = S_IDLE;
            S_OFFD:  if (expired(q.tmr, q.guard)) nxt = S_DIS;
            S_DIS:   if (expired(q.tmr, q.tflt)) nxt = S_IDLE;
        endcase

        // edges override the running phase; disable forces a turn-off
        if (!q.en) begin
            if (q.state != S_IDLE && q.state != S_DIS) nxt = S_DIS;
        end else if (rise) begin
            nxt = q.afw ? S_GUARD : S_PRE;
        end else if (fall && q.state != S_OFFD && q.state != S_DIS) begin
            nxt = q.afw ? S_OFFD : S_DIS;
        end

        // end of charge: compare measured delay and adapt
        if (q.state == S_CHG && nxt == S_POST) begin
            d.meas_stat = q.meas;
            d.hist      = {sht, lng};
            if (!q.filt) begin
                up = lng;
                dn = sht;
            end else begin
                up = lng && q.hist == 2'b01;
                dn = sht && q.hist == 2'b10;
            end
            if (q.adaptive_gate_control_sel[1]) begin
                d.pre_code = adjust(q.pre_code, up, dn, q.step, q.maxc);
            end
        end

        // phase entry: restart timer, latch code only at precharge start
        if (nxt != q.state) begin
            d.tmr = 8'h00;
            if (nxt == S_PRE) begin
                d.meas     = 8'h00;
                d.app_code = d.pre_code;
            end
        end
        d.state = nxt;

        // gate drive per phase; hold current whenever nothing switches
        d.hs = '{cur: hold, src: 1'b0};
        d.ls = '{cur: hold, src: 1'b0};
        unique case (nxt)
            S_IDLE: begin
                d.hs.src = q.en & q.sync2;
                d.ls.src = q.en & q.afw & ~q.sync2;
            end
            S_GUARD: d.ls.cur = q.fw;
            S_PRE:   d.hs = '{cur: d.app_code, src: 1'b1};
            S_CHG:   d.hs = '{cur: q.chg, src: 1'b1};
            S_POST: begin
                if (q.pcdis || q.state != S_POST) begin
                    d.hs = '{cur: q.chg, src: 1'b1};
                end else begin
                    d.hs = '{cur: min6(q.hs.cur + 6'h01, q.maxc), src: 1'b1};
                end
                if (!q.pcdis && q.state != S_POST) d.hs.cur = min6(q.chg + 6'h01, q.maxc);
            end
            S_OFFD:  d.hs.src = 1'b1;
            S_DIS:   d.hs.cur = q.en ? q.dchg : `HARD_SINK;
        endcase

        // wishbone classic slave, one wait state, single-cycle ack
        cur_rd = rdval(q, WB_ADR_I);
        for (int i = 0; i < 4; i++) begin
            wmrg[8*i +: 8] = WB_SEL_I[i] ? WB_DAT_I[8*i +: 8] : cur_rd[8*i +: 8];
        end
        d.ack  = WB_CYC_I & WB_STB_I & ~q.ack;
        d.rdat = (WB_CYC_I & WB_STB_I & ~q.ack & ~WB_WE_I) ? cur_rd : 32'h0000_0000;
        if (WB_CYC_I && WB_STB_I && !q.ack && WB_WE_I) begin
            unique case (WB_ADR_I)
                `OFS_GEN: begin
                    d.adaptive_gate_control_sel      = wmrg[`GEN_AGC_LSB +: 2];
                    d.filt     = wmrg[`GEN_FILT_BIT];
                    d.step     = wmrg[`GEN_STEP_BIT];
                    d.pcdis    = wmrg[`GEN_PCDIS_BIT];
                    d.hold_sel = wmrg[`GEN_HOLD_BIT];
                end
                `OFS_MODE: begin
                    d.en  = wmrg[`MODE_EN_BIT];
                    d.afw = wmrg[`MODE_AFW_BIT];
                    if (wmrg[`MODE_EN_BIT]) begin
                        d.pre_code = min6(q.init, q.maxc);
                        d.hist     = 2'b00;
                    end
                end
                `OFS_TIME: begin
                    d.pchg_t  = wmrg[7:0];
                    d.pdchg_t = wmrg[`B1_LSB +: 8];
                end
                `OFS_CUR: begin
                    d.chg  = wmrg[5:0];
                    d.dchg = wmrg[`B1_LSB +: 6];
                    d.fw   = wmrg[`B2_LSB +: 6];
                end
                `OFS_MAX:  d.maxc = wmrg[5:0];
                `OFS_INIT: d.init = wmrg[5:0];
                `OFS_TON: begin
                    d.ton   = wmrg[7:0];
                    d.guard = wmrg[`B1_LSB +: 8];
                    d.tflt  = wmrg[`B2_LSB +: 8];
                end
                default: ;                                       // status and holes ignore writes
            endcase
        end
    end

    // single state register
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            q <= RST_VAL;
        end else begin
            q <= d;
        end
    end

    assign WB_DAT_O = q.rdat;
    assign WB_ACK_O = q.ack;
    assign HS_CUR   = q.hs.cur;
    assign HS_SRC   = q.hs.src;
    assign LS_CUR   = q.ls.cur;
    assign LS_SRC   = q.ls.src;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    sequence rise_seen;
        q.en && q.afw && q.sync2 && !q.pwm_q;
    endsequence
    sequence fall_seen;
        q.en && q.afw && !q.sync2 && q.pwm_q && q.state == S_POST;
    endsequence

    a_guard_ls_sink: assert property (rise_seen |=> q.state == S_GUARD && !LS_SRC
        && LS_CUR == q.fw && !HS_SRC) else $error("guard phase drive wrong");
    a_pre_drive: assert property (q.state == S_PRE |-> HS_SRC && HS_CUR == q.app_code
        && q.tmr < q.pchg_t + 8'h01) else $error("precharge drive wrong");
    a_charge_end: assert property (q.state == S_CHG && SW_HIGH && q.en && !(q.sync2 ^ q.pwm_q)
        |=> q.state == S_POST && q.meas_stat == $past(q.meas)) else $error("charge end");
    a_post_ramp: assert property (q.state == S_POST && $past(q.state) == S_POST && !q.pcdis
        |-> HS_CUR == min6($past(HS_CUR) + 6'h01, q.maxc)) else $error("post ramp");
    a_code_bounds: assert property (q.maxc >= `MIN_STEP && q.adaptive_gate_control_sel[1]
        && $changed(q.pre_code) && !WB_WE_I |-> q.pre_code >= `MIN_STEP
        && q.pre_code <= q.maxc) else $error("code out of bounds");
    a_fixed_code: assert property (!q.adaptive_gate_control_sel[1] && !$past(q.adaptive_gate_control_sel[1]) && !$past(WB_STB_I)
        |-> $stable(q.pre_code)) else $error("code moved while fixed");
    a_passive_ls: assert property (!q.afw && !$past(q.afw) |-> !LS_SRC)
        else $error("low side on in passive mode");
    a_pre_stable: assert property (q.state == S_PRE && $past(q.state) == S_PRE
        |-> $stable(HS_CUR)) else $error("code changed inside precharge");
    a_off_delay: assert property (fall_seen |=> q.state == S_OFFD ##1 HS_SRC)
        else $error("turn-off not delayed");
    a_bus_ack: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("ack not one cycle");
endmodule : gate_turn_on_seq

// ===== dv/gate_load_model.sv
`timescale 1ns/1ps
module gate_load_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       hs_src,
    input  wire logic [7:0] delay_cyc,
    output logic            sw_high
);
    logic [7:0] cnt_q;

    // switch node climbs a set number of cycles after the high gate starts sourcing;
    // any sink on the gate pulls it straight back down
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q   <= 8'h00;
            sw_high <= 1'b0;
        end else if (!hs_src) begin
            cnt_q   <= 8'h00;
            sw_high <= 1'b0;
        end else begin
            cnt_q   <= (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
            sw_high <= ({1'b0, cnt_q} + 9'h001) >= {1'b0, delay_cyc};
        end
    end
endmodule : gate_load_model

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`include "gate_seq_params.svh"
module tb_top;
    typedef struct packed {
        logic [7:0] gen;
        logic [5:0] ini, mx;
        logic [7:0] d1, d2;
        logic [5:0] c0, c2;
    } row_t;
    localparam logic [7:0] long_d  = 8'h3C;
    localparam logic [7:0] short_d = 8'h0A;
    logic        clk, rst_b, pwm, cyc, stb, we, ack, hs_src, ls_src, sw_high;
    logic [7:0]  adr, dly;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rd;
    logic [5:0]  hs_cur, ls_cur;
    int          error_cnt = 0;
    int          samples_checked = 0;
    // reset values: address beside read data, last one unmapped
    logic [39:0] rstv [8] = '{40'h00_00000000, 40'h04_00000000, 40'h08_00000808,
        40'h0C_00101010, 40'h10_0000003F, 40'h14_00000008, 40'h18_00201020, 40'h20_00000000};
    // gen, init, max, two delays, first and third precharge codes
    row_t rows [12] = '{
        '{8'h02, 6'h08, 6'h3F, long_d, long_d, 6'h08, 6'h0A},
        '{8'h0A, 6'h08, 6'h3F, long_d, long_d, 6'h08, 6'h0C},
        '{8'h03, 6'h08, 6'h3F, short_d, short_d, 6'h08, 6'h06},
        '{8'h00, 6'h08, 6'h3F, long_d, long_d, 6'h08, 6'h08},
        '{8'h01, 6'h08, 6'h3F, long_d, long_d, 6'h08, 6'h08},
        '{8'h06, 6'h08, 6'h3F, long_d, long_d, 6'h08, 6'h09},
        '{8'h06, 6'h08, 6'h3F, long_d, short_d, 6'h08, 6'h08},
        '{8'h0E, 6'h08, 6'h3F, short_d, short_d, 6'h08, 6'h06},
        '{8'h0A, 6'h3F, 6'h11, long_d, long_d, 6'h11, 6'h11},
        '{8'h0A, 6'h01, 6'h3F, short_d, short_d, 6'h01, 6'h01},
        '{8'h12, 6'h08, 6'h3F, long_d, long_d, 6'h08, 6'h0A},
        '{8'h22, 6'h08, 6'h3F, long_d, long_d, 6'h08, 6'h0A}};

    gate_turn_on_seq uut (.REF_CLK(clk), .RST_B(rst_b), .PWM_IN(pwm), .SW_HIGH(sw_high),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .HS_CUR(hs_cur),
        .HS_SRC(hs_src), .LS_CUR(ls_cur), .LS_SRC(ls_src));
    gate_load_model load (.clk(clk), .rst_b(rst_b), .hs_src(hs_src), .delay_cyc(dly),
        .sw_high(sw_high));

    // 100 MHz reference
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // unknown bits must not slip through the range test
    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t got %h not in %h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    // classic cycle: hold until ack is sampled, release at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int k;
        @(posedge clk);
        {cyc, stb, we} <= {2'b11, w};
        adr <= a;
        sel <= s;
        wdat <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        if (k == 20) begin
            error_cnt++;
            $display("BAD %0t no bus answer", $time);
        end
        rd = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask : wb

    // one full turn-on and turn-off with guard 2, precharge 2, filter time 4
    task automatic pulse(input logic [7:0] d, input logic afw, input logic [7:0] g,
                         input logic [5:0] mx, output logic [5:0] code);
        int         n, ng = 0, np = 0, nc = 0;
        logic [5:0] e = 6'h10;
        logic [5:0] hold;
        hold = g[5] ? `HOLD_HI : `HOLD_LO;
        code = 6'h00;
        @(posedge clk);
        dly <= d;
        pwm <= 1'b1;
        for (n = 1; n < 40 && nc == 0; n++) begin
            step();
            if (ng == 0 && ls_cur === 6'h10 && ls_src === 1'b0) ng = n;
            if (np != 0 && n == np + 1) chk(hs_cur, code);
            if (np == 0 && hs_src === 1'b1) begin
                np = n;
                code = hs_cur;
            end
            if (np != 0 && hs_cur === 6'h10) nc = n;
        end
        chk(ng, afw ? 3 : 0);
        chk(np, afw ? 5 : 3);
        chk(nc - np, 2);
        for (n = 0; sw_high !== 1'b1 && n < 300; n++) step();
        repeat (3) begin
            step();
            e = (g[4] || e >= mx) ? e : e + 6'h01;
            chk(hs_cur, e);
        end
        repeat (5) step();
        chk({hs_src, hs_cur, ls_src, ls_cur}, {1'b1, hold, 1'b0, hold});
        wb(1'b0, `OFS_STAT, 4'hF, 32'h0);
        chk_rng(rd[7:0], d, d + 8'h02);
        @(posedge clk);
        pwm <= 1'b0;
        for (n = 0; hs_src !== 1'b0 && n < 40; n++) step();
        chk(n, afw ? 5 : 3);
        repeat (12) @(posedge clk);
    endtask : pulse

    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // main sequence
    initial begin
        int         i;
        logic [5:0] c;
        {rst_b, pwm, cyc, stb, we} = 5'h00;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        dly = short_d;
        repeat (5) step();
        chk({hs_src, hs_cur, ls_src, ls_cur}, 32'h0);
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        step();
        chk({hs_src, hs_cur, ls_src, ls_cur}, {1'b0, `HOLD_LO, 1'b0, `HOLD_LO});
        wb(1'b1, 8'h20, 4'hF, 32'hFFFFFFFF);
        foreach (rstv[k]) begin
            wb(1'b0, rstv[k][39:32], 4'hF, 32'h0);
            chk(rd, rstv[k][31:0]);
        end
        wb(1'b1, `OFS_TIME, 4'hF, 32'h000034FF);
        wb(1'b1, `OFS_TIME, 4'h1, 32'hFFFFFF02); // short precharge, below blank
        wb(1'b0, `OFS_TIME, 4'hF, 32'h0);
        chk(rd, 32'h00003402);
        wb(1'b1, `OFS_TON, 4'hF, 32'h00040220);
        for (i = 0; i < 12; i++) begin
            wb(1'b1, `OFS_GEN, 4'hF, {24'h0, rows[i].gen});
            wb(1'b1, `OFS_INIT, 4'hF, {26'h0, rows[i].ini});
            wb(1'b1, `OFS_MAX, 4'hF, {26'h0, rows[i].mx});
            wb(1'b1, `OFS_MODE, 4'hF, 32'h00000003);
            pulse(rows[i].d1, 1'b1, rows[i].gen, rows[i].mx, c);
            chk(c, rows[i].c0);
            pulse(rows[i].d2, 1'b1, rows[i].gen, rows[i].mx, c);
            pulse(long_d, 1'b1, rows[i].gen, rows[i].mx, c);
            chk(c, rows[i].c2);
        end
        // status is read-only: a write must not disturb the measurement
        wb(1'b1, `OFS_STAT, 4'hF, 32'h0);
        wb(1'b0, `OFS_STAT, 4'hF, 32'h0);
        chk_rng(rd[7:0], long_d, long_d + 8'h02);
        wb(1'b1, `OFS_MODE, 4'hF, 32'h00000001);
        pulse(short_d, 1'b0, rows[11].gen, rows[11].mx, c);
        // enable dropped inside a long charge phase: gate must be yanked off hard
        @(posedge clk);
        dly <= long_d;
        pwm <= 1'b1;
        repeat (30) @(posedge clk);
        wb(1'b1, `OFS_MODE, 4'hF, 32'h0);
        for (i = 0; hs_cur !== `HARD_SINK && i < 20; i++) @(posedge clk);
        #1;
        chk({hs_src, hs_cur}, {1'b0, `HARD_SINK});
        pwm <= 1'b0;
        summarize();
    end

    // run needs well under 20k cycles
    initial begin
        #300000;
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        summarize();
    end
endmodule : tb_top
